/* nand_data_read_busy_port.sv */
/*
 Host controller for the data, read and ready/busy part of an
 asynchronous parallel flash bus. It issues page reads and single data
 writes, waits on ready/busy or status, and stores fetched words.
 Assumes an external pull-up on the wired ready/busy line.
// Summary of operation
// - Write data with chip select, latches low
// - Data path sized by bus width setting
// - One read strobe pulse per word
// - Detect ready by line or status
// - Any device low means shared busy
// - Latch strobes select command, address, data
*/
`timescale 1ns/1ps
module nand_data_read_busy_port
    import nand_host_pkg::*;
(
    input wire logic clk_i, // 250 MHz clock
    input wire logic rst_n_i, // async reset, active low
    input wire logic wide_i, // 1 = sixteen-bit bus
    input wire logic use_status_i, // poll status instead of line
    input wire logic rd_start_i, // pulse: start page read
    input wire logic [39:0] rd_addr_i, // five address bytes
    input wire logic [PAGE_AW:0] rd_len_i, // words to fetch
    input wire logic wr_start_i, // pulse: write one data word
    input wire logic [DATA_W-1:0] wr_data_i, // data word to write
    input wire logic [PAGE_AW-1:0] buf_raddr_i, // buffer read address
    output logic [DATA_W-1:0] buf_rdata_o, // buffer read data
    output logic busy_o, // operation in progress
    output logic done_o, // pulse: operation finished
    output nand_ctrl_t ctrl_o, // flash control strobes
    output nand_dq_t dq_o, // data lines out and enables
    input wire logic [DATA_W-1:0] dq_i, // data lines in
    input wire logic ready_busy_n_i // wired ready/busy pin
);
    host_state_t state_r, state_nxt;
    nand_ctrl_t ctrl_r, ctrl_nxt;
    nand_dq_t dq_r, dq_nxt;
    logic [CNT_W-1:0] cnt_r, cnt_nxt;
    logic [2:0] idx_r, idx_nxt;
    logic [PAGE_AW:0] words_r, words_nxt;
    logic [39:0] addr_r, addr_nxt;
    logic [DATA_W-1:0] wdata_r, wdata_nxt;
    logic seen_busy_r, seen_busy_nxt;
    logic phase_r, phase_nxt;
    logic [2:0] rb_sync_r;
    logic rb_stable_r;
    logic done_r;
    logic [DATA_W-1:0] dq_s1_r, dq_s2_r, dq_s3_r;
    logic cap_we;
    logic [PAGE_AW-1:0] cap_addr;
    logic [DATA_W-1:0] bus_mask;
    logic cnt_zero;
    logic line_ready;
    logic status_ready;

    // Masking keeps the upper lines low on a byte-wide device.
    assign bus_mask = wide_i ? {DATA_W{1'b1}} : 16'h00FF;
    assign cnt_zero = (cnt_r == '0);
    assign line_ready = rb_stable_r;
    assign status_ready = dq_s3_r[STATUS_READY_BIT];
    assign cap_we = (state_r == ST_RDATA) && phase_r && cnt_zero;
    assign cap_addr = words_r[PAGE_AW-1:0];
    assign busy_o = (state_r != ST_IDLE);
    assign done_o = done_r;
    assign ctrl_o = ctrl_r;
    assign dq_o = dq_r;

    // Ready/busy is a pin: the second and third stages must agree.
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            rb_sync_r <= 3'h7;
            rb_stable_r <= 1'b1;
            dq_s1_r <= '0;
            dq_s2_r <= '0;
            dq_s3_r <= '0;
        end
        else
        begin
            rb_sync_r <= {rb_sync_r[1:0], ready_busy_n_i};
            if (rb_sync_r[2] == rb_sync_r[1])
            begin
                rb_stable_r <= rb_sync_r[2];
            end
            dq_s1_r <= dq_i;
            dq_s2_r <= dq_s1_r;
            dq_s3_r <= dq_s2_r;
        end
    end

    always_comb
    begin
        state_nxt = state_r;
        ctrl_nxt = ctrl_r;
        dq_nxt = dq_r;
        cnt_nxt = cnt_zero ? cnt_r : cnt_r - 8'h01;
        idx_nxt = idx_r;
        words_nxt = words_r;
        addr_nxt = addr_r;
        wdata_nxt = wdata_r;
        seen_busy_nxt = seen_busy_r;
        phase_nxt = phase_r;
        case (state_r)
            ST_IDLE:
            begin
                ctrl_nxt = '{ce_n: 1'b1, cle: 1'b0, ale: 1'b0,
                             we_n: 1'b1, read_strobe_n: 1'b1};
                // Idle lines are cleared so no stale upper lane survives.
                dq_nxt = '0;
                phase_nxt = 1'b0;
                // New cycles only start with the shared line ready.
                if (rd_start_i && line_ready)
                begin
                    addr_nxt = rd_addr_i;
                    words_nxt = '0;
                    idx_nxt = '0;
                    state_nxt = ST_CMD1;
                end
                else if (wr_start_i && line_ready)
                begin
                    wdata_nxt = wr_data_i;
                    state_nxt = ST_WDATA;
                end
            end
            ST_CMD1, ST_CMD2, ST_ADDR, ST_STCMD, ST_WDATA:
            begin
                // Each write cycle: strobe low, drive, then rising edge.
                if (cnt_zero && !phase_r)
                begin
                    ctrl_nxt.ce_n = 1'b0;
                    ctrl_nxt.we_n = 1'b0;
                    ctrl_nxt.cle = (state_r == ST_CMD1) ||
                        (state_r == ST_CMD2) || (state_r == ST_STCMD);
                    ctrl_nxt.ale = (state_r == ST_ADDR);
                    dq_nxt.dq_oe = bus_mask;
                    if (state_r == ST_WDATA)
                    begin
                        dq_nxt.dq = wdata_r & bus_mask;
                    end
                    else if (state_r == ST_ADDR)
                    begin
                        dq_nxt.dq = {8'h00, addr_r[8*idx_r +: 8]};
                    end
                    else if (state_r == ST_CMD1)
                    begin
                        dq_nxt.dq = {8'h00, CMD_READ_1};
                    end
                    else if (state_r == ST_CMD2)
                    begin
                        dq_nxt.dq = {8'h00, CMD_READ_2};
                    end
                    else
                    begin
                        dq_nxt.dq = {8'h00, CMD_STATUS};
                    end
                    cnt_nxt = CNT_W'(STROBE_LOW_CYC - 1);
                    phase_nxt = 1'b1;
                end
                else if (cnt_zero && phase_r)
                begin
                    // Rising edge latches; on CMD2 the array read begins.
                    ctrl_nxt.we_n = 1'b1;
                    cnt_nxt = CNT_W'(STROBE_HIGH_CYC - 1);
                    phase_nxt = 1'b0;
                    seen_busy_nxt = 1'b0;
                    case (state_r)
                        ST_CMD1: state_nxt = ST_ADDR;
                        ST_ADDR:
                        begin
                            idx_nxt = idx_r + 3'h1;
                            if (idx_r == 3'h4)
                            begin
                                state_nxt = ST_CMD2;
                            end
                        end
                        ST_CMD2: state_nxt = ST_BUSYW;
                        ST_STCMD: state_nxt = ST_STRD;
                        default: state_nxt = ST_DONE;
                    endcase
                    if (state_r == ST_CMD2)
                    begin
                        cnt_nxt = CNT_W'(BUSY_WAIT_CYC - 1);
                    end
                end
            end
            ST_BUSYW:
            begin
                dq_nxt.dq_oe = '0;
                ctrl_nxt.cle = 1'b0;
                ctrl_nxt.ale = 1'b0;
                // Array read time ends when the line is back high.
                if (!line_ready)
                begin
                    seen_busy_nxt = 1'b1;
                end
                if (use_status_i && cnt_zero)
                begin
                    state_nxt = ST_STCMD;
                end
                else if (seen_busy_r && line_ready)
                begin
                    state_nxt = ST_READY;
                end
                else if (cnt_zero && !seen_busy_r && line_ready)
                begin
                    // No busy seen in the window: too short to sample.
                    state_nxt = ST_READY;
                end
            end
            ST_STRD:
            begin
                // Status byte is fetched with one read strobe pulse.
                dq_nxt.dq_oe = '0;
                ctrl_nxt.cle = 1'b0;
                if (cnt_zero && !phase_r)
                begin
                    ctrl_nxt.read_strobe_n = 1'b0;
                    cnt_nxt = CNT_W'(STROBE_LOW_CYC + 2);
                    phase_nxt = 1'b1;
                end
                else if (cnt_zero && phase_r)
                begin
                    ctrl_nxt.read_strobe_n = 1'b1;
                    cnt_nxt = CNT_W'(STROBE_HIGH_CYC - 1);
                    phase_nxt = 1'b0;
                    state_nxt = status_ready ? ST_READY : ST_STCMD;
                end
            end
            ST_READY:
            begin
                // The device leaves status output at its ready report,
                // so data fetching goes on without a fresh command.
                state_nxt = ST_RDATA;
            end
            ST_RDATA:
            begin
                if (words_r == rd_len_i)
                begin
                    state_nxt = ST_DONE;
                end
                else if (cnt_zero && !phase_r)
                begin
                    ctrl_nxt.read_strobe_n = 1'b0;
                    cnt_nxt = CNT_W'(STROBE_LOW_CYC + 2);
                    phase_nxt = 1'b1;
                end
                else if (cnt_zero && phase_r)
                begin
                    ctrl_nxt.read_strobe_n = 1'b1;
                    cnt_nxt = CNT_W'(STROBE_HIGH_CYC - 1);
                    phase_nxt = 1'b0;
                    words_nxt = words_r + 1'b1;
                end
            end
            ST_DONE:
            begin
                ctrl_nxt.ce_n = 1'b1;
                dq_nxt.dq_oe = '0;
                state_nxt = ST_IDLE;
            end
            default:
            begin
                state_nxt = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            state_r <= ST_IDLE;
            ctrl_r <= '{ce_n: 1'b1, cle: 1'b0, ale: 1'b0,
                        we_n: 1'b1, read_strobe_n: 1'b1};
            dq_r <= '0;
            cnt_r <= '0;
            idx_r <= '0;
            words_r <= '0;
            addr_r <= '0;
            wdata_r <= '0;
            seen_busy_r <= 1'b0;
            phase_r <= 1'b0;
            done_r <= 1'b0;
        end
        else
        begin
            state_r <= state_nxt;
            ctrl_r <= ctrl_nxt;
            dq_r <= dq_nxt;
            cnt_r <= cnt_nxt;
            idx_r <= idx_nxt;
            words_r <= words_nxt;
            addr_r <= addr_nxt;
            wdata_r <= wdata_nxt;
            seen_busy_r <= seen_busy_nxt;
            phase_r <= phase_nxt;
            done_r <= (state_r == ST_DONE);
        end
    end

    // Word is taken just before the strobe rises, after sync delay.
    page_mem u_mem (
        .clk_i(clk_i),
        .we_i(cap_we),
        .waddr_i(cap_addr),
        .wdata_i(dq_s3_r & bus_mask),
        .raddr_i(buf_raddr_i),
        .rdata_o(buf_rdata_o)
    );
endmodule : nand_data_read_busy_port

/* nand_host_pkg.sv */
/*
 Package for the parallel flash host controller: bus carriers, command
 codes, states and timing counts.
 Assumes a 250 MHz system clock and an external pull-up on ready/busy.
*/
package nand_host_pkg;
    localparam int DATA_W = 16;
    localparam int PAGE_DEPTH = 64;
    localparam int PAGE_AW = 6;
    localparam logic [7:0] CMD_READ_1 = 8'h00;
    localparam logic [7:0] CMD_READ_2 = 8'h30;
    localparam logic [7:0] CMD_STATUS = 8'h70;
    localparam int STATUS_READY_BIT = 6;
    localparam int CLK_PERIOD_PS = 4000;
    localparam int STROBE_LOW_NS = 20;
    localparam int STROBE_HIGH_NS = 20;
    localparam int BUSY_WAIT_NS = 200;
    localparam int STROBE_LOW_CYC =
        (STROBE_LOW_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int STROBE_HIGH_CYC =
        (STROBE_HIGH_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int BUSY_WAIT_CYC =
        (BUSY_WAIT_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int CNT_W = 8;

    typedef struct packed {
        logic ce_n;
        logic cle;
        logic ale;
        logic we_n;
        logic read_strobe_n;
    } nand_ctrl_t;

    typedef struct packed {
        logic [DATA_W-1:0] dq;
        logic [DATA_W-1:0] dq_oe;
    } nand_dq_t;

    typedef enum logic [3:0] {
        ST_IDLE = 4'h0,
        ST_CMD1 = 4'h1,
        ST_ADDR = 4'h3,
        ST_CMD2 = 4'h2,
        ST_BUSYW = 4'h6,
        ST_READY = 4'h7,
        ST_RDATA = 4'h5,
        ST_DONE = 4'h4,
        ST_STCMD = 4'hC,
        ST_STRD = 4'hD,
        ST_WDATA = 4'hE
    } host_state_t;
endpackage : nand_host_pkg

/* page_mem.sv */
/*
 Small page buffer for words fetched from the flash.
 Assumes one writer and one reader on the same clock.
*/
`timescale 1ns/1ps
module page_mem
    import nand_host_pkg::*;
(
    input wire logic clk_i, // system clock
    input wire logic we_i, // write enable
    input wire logic [PAGE_AW-1:0] waddr_i, // write address
    input wire logic [DATA_W-1:0] wdata_i, // write data
    input wire logic [PAGE_AW-1:0] raddr_i, // read address
    output logic [DATA_W-1:0] rdata_o // registered read data
);
    logic [DATA_W-1:0] mem [PAGE_DEPTH];

    always_ff @(posedge clk_i)
    begin
        if (we_i)
        begin
            mem[waddr_i] <= wdata_i;
        end
        rdata_o <= mem[raddr_i];
    end
endmodule : page_mem

/* nand_port_monitor.sv */
/*
 Checker for the flash host port, watching the top-level ports only.
 Assumes the bind below and a 3-flop sync on the ready/busy pin.
*/
`timescale 1ns/1ps
module nand_port_monitor
    import nand_host_pkg::*;
(
    input wire logic clk_i, // clock
    input wire logic rst_n_i, // reset, active low
    input wire logic wide_i, // bus width
    input wire logic use_status_i, // status polling
    input wire logic rd_start_i, // read start
    input wire logic ready_busy_n_i, // wired line
    input wire logic busy_o, // busy
    input wire logic done_o, // done pulse
    input nand_ctrl_t ctrl_o, // strobes
    input nand_dq_t dq_o // data out
);
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!rst_n_i);

    latch_excl_a: assert property (!(ctrl_o.cle && ctrl_o.ale))
        else $error("both latch strobes high");
    strobe_excl_a: assert property (
        ctrl_o.we_n || ctrl_o.read_strobe_n)
        else $error("write and read strobes low together");
    we_width_a: assert property ($fell(ctrl_o.we_n) |->
        (!ctrl_o.we_n) [*5] ##1 ctrl_o.we_n)
        else $error("write strobe low width wrong");
    re_width_a: assert property ($fell(ctrl_o.read_strobe_n) |->
        (!ctrl_o.read_strobe_n) [*8] ##1 ctrl_o.read_strobe_n)
        else $error("read strobe low width wrong");
    data_cycle_a: assert property (!ctrl_o.we_n && !ctrl_o.cle &&
        !ctrl_o.ale |-> !ctrl_o.ce_n && dq_o.dq_oe != '0)
        else $error("data cycle without select or drive");
    byte_lane_a: assert property (!wide_i && !$past(wide_i) |->
        dq_o.dq[15:8] == 8'h00 && dq_o.dq_oe[15:8] == 8'h00)
        else $error("upper lane not zero in byte mode");
    refuse_busy_a: assert property ((!ready_busy_n_i) [*5] ##0
        (rd_start_i && !busy_o) |=> !busy_o)
        else $error("start taken while line busy");
    take_ready_a: assert property (ready_busy_n_i [*5] ##0
        (rd_start_i && !busy_o) |=> busy_o)
        else $error("start not taken while ready");
    no_read_busy_a: assert property (!use_status_i &&
        (!ready_busy_n_i) [*4] |-> ctrl_o.read_strobe_n)
        else $error("read strobe while line busy");
    done_pulse_a: assert property (done_o |-> !busy_o ##1 !done_o)
        else $error("done not a single idle pulse");
endmodule : nand_port_monitor

bind nand_data_read_busy_port nand_port_monitor i_mon (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .wide_i(wide_i),
    .use_status_i(use_status_i),
    .rd_start_i(rd_start_i),
    .ready_busy_n_i(ready_busy_n_i),
    .busy_o(busy_o),
    .done_o(done_o),
    .ctrl_o(ctrl_o),
    .dq_o(dq_o)
);

/* flash_dev_model.sv */
/*
 Behavioural flash device: strobe driven, open-drain ready/busy.
 Assumes the bench resolves the data and ready/busy wires.
*/
`timescale 1ns/1ps
module flash_dev_model
    import nand_host_pkg::*;
#(
    parameter int ARRAY_READ_NS = 2000 // array_read_time
)
(
    input nand_ctrl_t ctrl_i, // host strobes
    input wire logic [DATA_W-1:0] pin_i, // resolved data lines
    input wire logic wide_i, // bus width
    output logic [DATA_W-1:0] dq_o, // device data drive
    output logic pull_low_o, // pulls ready/busy low
    output logic [DATA_W-1:0] data_o, // captured data word
    output logic [7:0] wr_cnt_o, // data cycles taken
    output logic [7:0] rd_cnt_o, // words presented
    output logic stat_o // status command seen
);
    logic [7:0] seed_r = 8'h00;
    logic [7:0] ptr_r = 8'h00;
    logic stat_r = 1'b0;
    logic [DATA_W-1:0] last = 16'h0000;
    int na = 0;
    initial
    begin
        {pull_low_o, stat_o, wr_cnt_o, rd_cnt_o} = '0;
        data_o = '0;
        dq_o = 16'hFFFF;
    end
    // Busy ignores all but status and reset commands.
    always @(posedge ctrl_i.we_n)
    begin
        if (!ctrl_i.ce_n && ctrl_i.cle && (!pull_low_o ||
            pin_i[7:0] == CMD_STATUS || pin_i[7:0] == 8'hFF))
        begin
            stat_r = (pin_i[7:0] == CMD_STATUS);
            stat_o = stat_o | stat_r;
            if (pin_i[7:0] == CMD_READ_1)
                na = 0;
            if (pin_i[7:0] == CMD_READ_2)
            begin
                ptr_r = 8'h00;
                pull_low_o = 1'b1;
                pull_low_o <= #(ARRAY_READ_NS) 1'b0;
            end
        end
        else if (!ctrl_i.ce_n && ctrl_i.ale && !pull_low_o)
        begin
            if (na == 0)
                seed_r = pin_i[7:0];
            na++;
        end
        else if (!ctrl_i.ce_n && !pull_low_o)
        begin
            data_o = wide_i ? pin_i : {8'h00, pin_i[7:0]};
            wr_cnt_o++;
        end
    end
    // Status mode ends at the first ready report, as the host reads on.
    always @(negedge ctrl_i.read_strobe_n)
    begin
        if (!ctrl_i.ce_n && stat_r)
        begin
            last = pull_low_o ? 16'h0000 : 16'h0040;
            stat_r = pull_low_o;
        end
        else if (!ctrl_i.ce_n)
        begin
            last = {seed_r, ptr_r};
            ptr_r++;
            rd_cnt_o++;
        end
        #8 dq_o = last;
    end
    // A released bus shows the inverse so stale data cannot pass.
    always @(posedge ctrl_i.read_strobe_n)
        #3 dq_o = ~last;
endmodule : flash_dev_model

/* tb_nand_data_read_busy_port.sv */
/*
 Self-checking bench for the flash host port with a device model.
 Assumes a pull-up on ready/busy and a second device sharing it.
*/
`timescale 1ns/1ps
module tb_nand_data_read_busy_port
    import nand_host_pkg::*;
();
    logic clk_i = 0, rst_n_i = 0, wide_i = 1, use_status_i = 0;
    logic rd_start_i = 0, wr_start_i = 0, ext_low = 0;
    logic [39:0] rd_addr_i = '0;
    logic [PAGE_AW:0] rd_len_i = '0;
    logic [DATA_W-1:0] wr_data_i = '0, buf_rdata_o, dev_dq, pin, dev_data;
    logic [PAGE_AW-1:0] buf_raddr_i = '0;
    logic busy_o, done_o, pull, stat;
    logic [7:0] wr_n, rd_n;
    nand_ctrl_t ctrl_o;
    nand_dq_t dq_o;
    int n_mismatch = 0, checked = 0, seen_low = 0;
    wire rb_n = !(pull || ext_low);
    assign pin = (dq_o.dq & dq_o.dq_oe) | (dev_dq & ~dq_o.dq_oe);
    always #2 clk_i = ~clk_i;
    always @(negedge rb_n) seen_low++;

    nand_data_read_busy_port i_dut (.clk_i(clk_i), .rst_n_i(rst_n_i),
        .wide_i(wide_i), .use_status_i(use_status_i),
        .rd_start_i(rd_start_i), .rd_addr_i(rd_addr_i),
        .rd_len_i(rd_len_i), .wr_start_i(wr_start_i),
        .wr_data_i(wr_data_i), .buf_raddr_i(buf_raddr_i),
        .buf_rdata_o(buf_rdata_o), .busy_o(busy_o), .done_o(done_o),
        .ctrl_o(ctrl_o), .dq_o(dq_o), .dq_i(pin), .ready_busy_n_i(rb_n));
    flash_dev_model i_dev (.ctrl_i(ctrl_o), .pin_i(pin), .wide_i(wide_i),
        .dq_o(dev_dq), .pull_low_o(pull), .data_o(dev_data),
        .wr_cnt_o(wr_n), .rd_cnt_o(rd_n), .stat_o(stat));

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        checked++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check
    task automatic wait_done();
        for (int i = 0; i < 6000 && done_o !== 1'b1; i++)
        begin
            @(posedge clk_i);
            #1;
        end
        check(done_o, 1'b1);
    endtask : wait_done
    task automatic do_write(input logic w, input logic [15:0] d);
        @(posedge clk_i);
        wide_i <= w;
        wr_data_i <= d;
        wr_start_i <= 1'b1;
        @(posedge clk_i);
        wr_start_i <= 1'b0;
        wait_done();
    endtask : do_write
    task automatic do_read(input logic st, input logic [6:0] n,
        input logic [7:0] a);
        @(posedge clk_i);
        use_status_i <= st;
        rd_len_i <= n;
        rd_addr_i <= {32'h0, a};
        rd_start_i <= 1'b1;
        @(posedge clk_i);
        rd_start_i <= 1'b0;
        wait_done();
        for (int i = 0; i < n; i++)
        begin
            @(posedge clk_i);
            buf_raddr_i <= i[5:0];
            repeat (2) @(posedge clk_i);
            #1;
            check(buf_rdata_o, {a, i[7:0]});
        end
    endtask : do_read
    task automatic t_write();
        do_write(1'b1, 16'hC3A5);
        check(dev_data, 16'hC3A5);
        do_write(1'b0, 16'hC35A);
        check(dev_data, 16'h005A);
        check({8'h00, wr_n}, 16'h0002);
        @(posedge clk_i);
        wide_i <= 1'b1;
    endtask : t_write
    task automatic t_read_line();
        int s0 = seen_low;
        logic [7:0] r0 = rd_n;
        do_read(1'b0, 7'd4, 8'h12);
        check(16'(seen_low - s0), 16'h0001);
        check({8'h00, rd_n - r0}, 16'h0004);
        do_read(1'b0, 7'd64, 8'hA7);
        check({8'h00, rd_n - r0}, 16'h0044);
    endtask : t_read_line
    task automatic t_read_status();
        do_read(1'b1, 7'd2, 8'h3C);
        check({15'h0, stat}, 16'h0001);
    endtask : t_read_status
    task automatic t_shared();
        @(posedge clk_i);
        ext_low <= 1'b1;
        repeat (6) @(posedge clk_i);
        rd_start_i <= 1'b1;
        @(posedge clk_i);
        rd_start_i <= 1'b0;
        repeat (20) @(posedge clk_i);
        #1;
        check({15'h0, busy_o}, 16'h0000);
        ext_low <= 1'b0;
        repeat (6) @(posedge clk_i);
        do_read(1'b0, 7'd1, 8'h55);
    endtask : t_shared
    task automatic results();
        $display("checked=%0d n_mismatch=%0d", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : results

    initial
    begin
        repeat (4) @(posedge clk_i);
        rst_n_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        t_write();
        t_read_line();
        t_read_status();
        t_shared();
        results();
    end
    // Reads take about 3600 cycles; this allows ten times that.
    initial
    begin
        #150000;
        n_mismatch++;
        results();
    end
endmodule : tb_nand_data_read_busy_port
